// ---- verif/ipeb_properties.sv ----
// concurrent checks on the enable bank ports
`timescale 1ns/1ps
module ipeb_properties
    import ipeb_pkg::*;
(
    input wire logic              clk_sys_in,
    input wire logic              reset_in,
    input wire logic [ADDR_W-1:0] reg_addr_in,
    input wire logic [DATA_W-1:0] reg_wdata_in,
    input wire logic              reg_wr_in,
    input wire logic              reg_rd_in,
    input wire logic [DATA_W-1:0] reg_rdata_out,
    input wire logic [7:0]        request_group_zero_in,
    input wire logic [7:0]        port_a_request_in,
    input wire logic [7:0]        port_d_request_in,
    input wire logic [7:0]        request_group_two_in,
    input wire logic [7:0]        pin_port_chooser_in,
    input wire logic              global_int_enable_in,
    input wire logic              cpu_request_out,
    input wire ipeb_level_t       cpu_level_out,
    input wire logic [IDX_W-1:0]  cpu_index_out,
    input wire logic [GROUPS-1:0] group_enabled_out
);
    logic is_en;
    assign is_en = reg_addr_in inside {OFS_G0_EN_HIGH, OFS_G0_EN_LOW,
        OFS_G1_EN_HIGH, OFS_G1_EN_LOW, OFS_G2_EN_HIGH, OFS_G2_EN_LOW};
    default clocking @(posedge clk_sys_in); endclocking
    default disable iff (reset_in);
    // a write, one quiet cycle, then a read of the same enable register
    sequence s_wr_rd;
        reg_wr_in && is_en ##1 !reg_wr_in
            ##1 reg_rd_in && reg_addr_in == $past(reg_addr_in, 2);
    endsequence
    rd_idle_zero_a: assert property (!reg_rd_in |=>
        reg_rdata_out == 8'h00)
        else $error("read data not zero outside read");
    wr_rd_back_a: assert property (s_wr_rd |=>
        reg_rdata_out == $past(reg_wdata_in, 3))
        else $error("enable register readback differs");
    gie_blocks_a: assert property (!global_int_enable_in |=>
        !cpu_request_out)
        else $error("request forwarded while disabled");
    fwd_level_on_a: assert property (cpu_request_out |->
        cpu_level_out != IPEB_LVL_OFF)
        else $error("forwarded request at level off");
    fwd_group_on_a: assert property (cpu_request_out |->
        group_enabled_out[cpu_index_out[4:3]])
        else $error("winner group not enabled");
    g0_empty_a: assert property (request_group_zero_in == 8'h00 |=>
        !group_enabled_out[0])
        else $error("group 0 enabled with no request");
    g1_port_sel_a: assert property (pin_port_chooser_in == 8'h00 &&
        port_a_request_in == 8'h00 |=> !group_enabled_out[1])
        else $error("group 1 enabled from unselected port");
    g2_empty_a: assert property (request_group_two_in == 8'h00 |=>
        !group_enabled_out[2])
        else $error("group 2 enabled with no request");
    no_pend_idle_a: assert property (port_a_request_in == 8'h00 &&
        port_d_request_in == 8'h00 && request_group_zero_in == 8'h00 &&
        request_group_two_in == 8'h00 |=> !cpu_request_out)
        else $error("request forwarded with nothing pending");
endmodule
bind ipeb_bank ipeb_properties chk_u (.*);

// ---- verif/ipeb_req_model.sv ----
// request register model: sticky pending bits fed by source pulses
`timescale 1ns/1ps
module ipeb_req_model (
    input  wire logic        clk_sys_in,
    input  wire logic        reset_in,
    input  wire logic [31:0] pulse_in,
    input  wire logic [31:0] clr_in,
    output logic      [31:0] pend_out
);
    // ------------------------------------------------------------
    // [7:0] group 0, [15:8] port a, [23:16] port d, [31:24] group 2
    // ------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            pend_out <= 32'h0000_0000;
        end else begin
            pend_out <= (pend_out & ~clr_in) | pulse_in;
        end
    end
endmodule

// ---- verif/tb.sv ----
// self-checking bench for the interrupt priority enable bank
`timescale 1ns/1ps
module tb
    import ipeb_pkg::*;
;
    logic        clk_sys_in = 1'b0;
    logic        reset_in   = 1'b1;
    logic [11:0] addr       = 12'h000;
    logic [7:0]  wdata      = 8'h00;
    logic        wr         = 1'b0;
    logic        rd         = 1'b0;
    logic [7:0]  rdata;
    logic [31:0] pulse      = 32'h0;
    logic [31:0] clr        = 32'h0;
    logic [31:0] pend;
    logic [7:0]  pps        = 8'h00;
    logic        gie        = 1'b1;
    logic        req;
    ipeb_level_t lvl_o;
    logic [4:0]  idx;
    logic [2:0]  grp;
    logic        irq;
    int          errors     = 0;
    int          tests_run  = 0;
    always #10 clk_sys_in = ~clk_sys_in;
    ipeb_req_model src_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .pulse_in(pulse), .clr_in(clr), .pend_out(pend));
    ipeb_bank dut_u (.clk_sys_in(clk_sys_in), .reset_in(reset_in),
        .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_wr_in(wr),
        .reg_rd_in(rd), .reg_rdata_out(rdata),
        .request_group_zero_in(pend[7:0]), .port_a_request_in(pend[15:8]),
        .port_d_request_in(pend[23:16]), .request_group_two_in(pend[31:24]),
        .pin_port_chooser_in(pps), .global_int_enable_in(gie),
        .cpu_request_out(req), .cpu_level_out(lvl_o), .cpu_index_out(idx),
        .group_enabled_out(grp), .event_irq_out(irq));
    // ------------------------------------------------------------
    // tasks
    // ------------------------------------------------------------
    task automatic chk(input string n, input logic [7:0] s, e);
        tests_run++;
        if (s !== e) begin
            errors++;
            $display("Error %s expected %h seen %h", n, e, s);
        end
    endtask
    // enable registers in order: group 0 high/low, group 1, group 2
    function automatic logic [11:0] en_ofs(input int i);
        return 12'(12'hFC1 + i + i / 2);
    endfunction
    task automatic wrr(input logic [11:0] a, input logic [7:0] d);
        @(posedge clk_sys_in);
        addr <= a; wdata <= d; wr <= 1'b1;
        @(posedge clk_sys_in);
        wr <= 1'b0;
    endtask
    task automatic rdr(input logic [11:0] a, input logic [7:0] e);
        @(posedge clk_sys_in);
        addr <= a; rd <= 1'b1;
        @(posedge clk_sys_in);
        rd <= 1'b0;
        #1 chk("rdata", rdata, e);
    endtask
    task automatic pls(input logic [31:0] p, c);
        @(posedge clk_sys_in);
        pulse <= p; clr <= c;
        @(posedge clk_sys_in);
        pulse <= 32'h0; clr <= 32'h0;
    endtask
    task automatic settle();
        repeat (3) @(posedge clk_sys_in);
        #1;
    endtask
    task automatic outs(input logic r, input logic [1:0] l,
                        input logic [4:0] i);
        chk("request", {7'h00, req}, {7'h00, r});
        chk("level", {6'h00, lvl_o}, {6'h00, l});
        chk("index", {3'h0, idx}, {3'h0, i});
    endtask
    // one source of group g, bit b, at enable pair p
    task automatic lvl(input int g, b, input logic [1:0] p);
        logic [7:0] ge;
        ge = (p != 2'b00) ? 8'(1 << g) : 8'h00;
        wrr(12'(12'hFC1 + 3 * g), 8'(p[1]) << b);
        wrr(12'(12'hFC2 + 3 * g), 8'(p[0]) << b);
        pls(32'h1 << (g * 8 + b + ((g == 2) ? 8 : 0)), 32'h0);
        settle();
        outs(|p, p, (p != 2'b00) ? 5'(g * 8 + b) : 5'h00);
        chk("group", {5'h00, grp}, ge);
        wrr(12'(12'hFC1 + 3 * g), 8'h00);
        wrr(12'(12'hFC2 + 3 * g), 8'h00);
        pls(32'h0, 32'hFFFF_FFFF);
    endtask
    task automatic stop_test();
        $display("tests_run %0d errors %0d", tests_run, errors);
        if (errors == 0 && tests_run > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // tests
    // ------------------------------------------------------------
    initial begin
        repeat (4) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 6; i++) rdr(en_ofs(i), 8'h00);
        for (int i = 0; i < 6; i++) begin
            wrr(en_ofs(i), 8'(8'h5A + i));
            rdr(en_ofs(i), 8'(8'h5A + i));
            wrr(en_ofs(i), 8'h00);
        end
        wrr(12'hFC3, 8'hFF);
        rdr(12'hFC3, 8'h00);
        for (int g = 0; g < 3; g++) begin
            for (int p = 0; p < 4; p++) lvl(g, 2 * g + 1, 2'(p));
        end
        // port d pin 2 feeds group 1 only once selected
        wrr(12'hFC4, 8'h04);
        wrr(12'hFC5, 8'h04);
        pls(32'h0004_0000, 32'h0);
        settle();
        outs(1'b0, 2'b00, 5'h00);
        @(posedge clk_sys_in);
        pps <= 8'h04;
        settle();
        outs(1'b1, 2'b11, 5'd10);
        wrr(12'hFC4, 8'h00);
        wrr(12'hFC5, 8'h00);
        pls(32'h0, 32'hFFFF_FFFF);
        // level 1 on adc against level 3 on timer 3
        wrr(12'hFC2, 8'h01);
        wrr(12'hFC7, 8'h80);
        wrr(12'hFC8, 8'h80);
        pls(32'h8000_0001, 32'h0);
        settle();
        outs(1'b1, 2'b11, 5'd23);
        @(posedge clk_sys_in);
        gie <= 1'b0;
        settle();
        outs(1'b0, 2'b11, 5'd23);
        @(posedge clk_sys_in);
        gie <= 1'b1;
        // event status, mask and interrupt line
        pls(32'h0, 32'hFFFF_FFFF);
        wrr(12'hFC9, 8'h0F);
        pls(32'h1, 32'h0);
        settle();
        rdr(12'hFC9, 8'h01);
        chk("irq", {7'h00, irq}, 8'h00);
        wrr(12'hFCA, 8'h01);
        #1 chk("irq", {7'h00, irq}, 8'h01);
        wrr(12'hFC9, 8'h01);
        #1 chk("irq", {7'h00, irq}, 8'h00);
        pls(32'h20, 32'h0);
        settle();
        rdr(12'hFC9, 8'h08);
        // a reset in mid-run must clear every enable and the request, level and index outputs
        @(posedge clk_sys_in);
        reset_in <= 1'b1;
        repeat (2) @(posedge clk_sys_in);
        reset_in <= 1'b0;
        for (int i = 0; i < 6; i++) rdr(en_ofs(i), 8'h00);
        outs(1'b0, 2'b00, 5'h00);
        stop_test();
    end
    initial begin
        #100000;
        errors++;
        stop_test();
    end
endmodule

// ---- verilog/ipeb_arbiter.sv ----
// combinational pick of the highest-level pending enabled source
`timescale 1ns/1ps
module ipeb_arbiter
    import ipeb_pkg::*;
#(
    parameter int N = SRC_N
) (
    input  wire logic [N-1:0]     req_in,
    input  wire logic [N-1:0]     en_high_in,
    input  wire logic [N-1:0]     en_low_in,
    output logic                  found_out,
    output ipeb_level_t           level_out,
    output logic [IDX_W-1:0]      index_out
);

    ipeb_level_t    lvl;
    logic [1:0]     best;

    // ties go to the lowest index, so group 0 bit 0 wins among equals
    always_comb begin
        found_out = 1'b0;
        best      = 2'b00;
        index_out = '0;
        lvl       = IPEB_LVL_OFF;
        for (int i = 0; i < N; i++) begin
            lvl = ipeb_decode(en_high_in[i], en_low_in[i]);
            // an off source never competes [R9]
            if (req_in[i] && lvl != IPEB_LVL_OFF &&
                logic'(2'(lvl) > best)) begin
                best      = 2'(lvl);
                found_out = 1'b1;
                index_out = IDX_W'(i);
            end
        end
        level_out = ipeb_level_t'(best);
    end

endmodule

// ---- verilog/ipeb_bank.sv ----
// interrupt priority enable bank: enable registers, decode and forwarding
//
// Local design decision: strobed register access.
`timescale 1ns/1ps
module ipeb_bank
    import ipeb_pkg::*;
(
    input  wire logic               clk_sys_in,
    input  wire logic               reset_in,
    // register port
    input  wire logic [ADDR_W-1:0]  reg_addr_in,
    input  wire logic [DATA_W-1:0]  reg_wdata_in,
    input  wire logic               reg_wr_in,
    input  wire logic               reg_rd_in,
    output logic [DATA_W-1:0]       reg_rdata_out,
    // pending request bits from the request registers
    input  wire logic [7:0]         request_group_zero_in,
    input  wire logic [7:0]         port_a_request_in,
    input  wire logic [7:0]         port_d_request_in,
    input  wire logic [7:0]         request_group_two_in,
    input  wire logic [7:0]         pin_port_chooser_in,
    input  wire logic               global_int_enable_in,
    // toward the cpu
    output logic                    cpu_request_out,
    output ipeb_level_t             cpu_level_out,
    output logic [IDX_W-1:0]        cpu_index_out,
    output logic [GROUPS-1:0]       group_enabled_out,
    output logic                    event_irq_out
);

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [GROUPS-1:0][7:0] en_high;
        logic [GROUPS-1:0][7:0] en_low;
        logic [EVT_N-1:0]       evt_status;
        logic [EVT_N-1:0]       evt_mask;
        logic [GROUPS-1:0]      grp_seen;
        logic                   drop_seen;
        logic [DATA_W-1:0]      rdata;
        logic                   fwd;
        ipeb_level_t            level;
        logic [IDX_W-1:0]       index;
    } ipeb_state_t;

    ipeb_state_t s_r;
    ipeb_state_t s_nxt;

    // ------------------------------------------------------------------
    // source assembly
    // ------------------------------------------------------------------
    logic [GROUPS-1:0][7:0] req;
    logic [SRC_N-1:0]       req_flat;
    logic [SRC_N-1:0]       high_flat;
    logic [SRC_N-1:0]       low_flat;
    logic [GROUPS-1:0]      grp_live;
    logic [SRC_N-1:0]       drop_vec;
    logic                   arb_found;
    ipeb_level_t            arb_level;
    logic [IDX_W-1:0]       arb_index;

    always_comb begin
        // group 0 bit order is fixed by the source wiring [R4]
        req[0] = request_group_zero_in;
        // each group 1 bit follows the port the chooser assigns [R5]
        req[1] = (pin_port_chooser_in & port_d_request_in) |
                 (~pin_port_chooser_in & port_a_request_in);
        // group 2: timer 3, uart 1 rx/tx, dma, port c pins 3..0 [R6]
        req[2] = request_group_two_in;
    end

    assign req_flat  = req;
    assign high_flat = s_r.en_high;
    assign low_flat  = s_r.en_low;

    genvar g;
    generate
        for (g = 0; g < GROUPS; g++) begin : g_grp
            // a group is live if any pending bit has a non-off pair
            // [R1] [R2] [R3]
            assign grp_live[g] = |(req[g] & (s_r.en_high[g] |
                                             s_r.en_low[g]));
            assign drop_vec[g*8 +: 8] = req[g] & ~(s_r.en_high[g] |
                                                   s_r.en_low[g]);
        end
    endgenerate

    ipeb_arbiter #(
        .N (SRC_N)
    ) u_arb (
        .req_in     (req_flat),
        .en_high_in (high_flat),
        .en_low_in  (low_flat),
        .found_out  (arb_found),
        .level_out  (arb_level),
        .index_out  (arb_index)
    );

    // ------------------------------------------------------------------
    // register decode
    // ------------------------------------------------------------------
    function automatic logic [DATA_W-1:0] read_mux(
        input ipeb_state_t      st,
        input logic [ADDR_W-1:0] a);
        logic [DATA_W-1:0] d;
        d = 8'h00;
        unique case (a)
            OFS_G0_EN_HIGH: d = st.en_high[0];
            OFS_G0_EN_LOW:  d = st.en_low[0];
            OFS_G1_EN_HIGH: d = st.en_high[1];
            OFS_G1_EN_LOW:  d = st.en_low[1];
            OFS_G2_EN_HIGH: d = st.en_high[2];
            OFS_G2_EN_LOW:  d = st.en_low[2];
            OFS_EVT_STATUS: d = {4'h0, st.evt_status};
            OFS_EVT_MASK:   d = {4'h0, st.evt_mask};
            OFS_ACTIVE:     d = {st.fwd, 2'(st.level), st.index};
            default:        d = 8'h00;
        endcase
        return d;
    endfunction

    // ------------------------------------------------------------------
    // next state
    // ------------------------------------------------------------------
    logic [EVT_N-1:0] evt_set;
    logic [EVT_N-1:0] evt_clr;

    always_comb begin
        s_nxt   = s_r;
        evt_clr = '0;
        if (reg_wr_in) begin
            unique case (reg_addr_in)
                OFS_G0_EN_HIGH: s_nxt.en_high[0] = reg_wdata_in;
                OFS_G0_EN_LOW:  s_nxt.en_low[0]  = reg_wdata_in;
                OFS_G1_EN_HIGH: s_nxt.en_high[1] = reg_wdata_in;
                OFS_G1_EN_LOW:  s_nxt.en_low[1]  = reg_wdata_in;
                OFS_G2_EN_HIGH: s_nxt.en_high[2] = reg_wdata_in;
                // own address for the group 2 low enable [R7]
                OFS_G2_EN_LOW:  s_nxt.en_low[2]  = reg_wdata_in;
                OFS_EVT_STATUS: evt_clr = reg_wdata_in[EVT_N-1:0];
                OFS_EVT_MASK:   s_nxt.evt_mask = reg_wdata_in[EVT_N-1:0];
                default:        ;
            endcase
        end
        // read data stand only in the cycle after the strobe
        s_nxt.rdata = reg_rd_in ? read_mux(s_r, reg_addr_in) : 8'h00;

        // events: a group turning live, or a pending source left off
        evt_set                 = '0;
        evt_set[EVT_G0_NEW]     = grp_live[0] & ~s_r.grp_seen[0];
        evt_set[EVT_G1_NEW]     = grp_live[1] & ~s_r.grp_seen[1];
        evt_set[EVT_G2_NEW]     = grp_live[2] & ~s_r.grp_seen[2];
        evt_set[EVT_DROPPED]    = (|drop_vec) & ~s_r.drop_seen;
        s_nxt.grp_seen          = grp_live;
        s_nxt.drop_seen         = |drop_vec;
        // a set in the clearing cycle survives the clear
        s_nxt.evt_status = (s_r.evt_status & ~evt_clr) | evt_set;

        // highest level wins; never forwarded while disabled [R8] [R9]
        s_nxt.fwd   = arb_found & global_int_enable_in;
        s_nxt.level = arb_found ? arb_level : IPEB_LVL_OFF;
        s_nxt.index = arb_found ? arb_index : '0;
    end

    // ------------------------------------------------------------------
    // registers
    // ------------------------------------------------------------------
    always_ff @(posedge clk_sys_in or posedge reset_in) begin
        if (reset_in) begin
            s_r.en_high    <= {GROUPS{RST_ENABLE}};
            s_r.en_low     <= {GROUPS{RST_ENABLE}};
            s_r.evt_status <= RST_EVT_STATUS[EVT_N-1:0];
            s_r.evt_mask   <= RST_EVT_MASK[EVT_N-1:0];
            s_r.grp_seen   <= '0;
            s_r.drop_seen  <= 1'b0;
            s_r.rdata      <= 8'h00;
            s_r.fwd        <= 1'b0;
            s_r.level      <= IPEB_LVL_OFF;
            s_r.index      <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ------------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------------
    assign reg_rdata_out     = s_r.rdata;
    assign cpu_request_out   = s_r.fwd;
    assign cpu_level_out     = s_r.level;
    assign cpu_index_out     = s_r.index;
    assign group_enabled_out = s_r.grp_seen;
    assign event_irq_out     = |(s_r.evt_status & s_r.evt_mask);

endmodule

// ---- verilog/ipeb_pkg.sv ----
// constants, types and decode helpers for the interrupt priority enable bank
// How it works
// R1: group 0 enable pair selects off or level 1-3
// R2: group 1 enable pair decodes the same way
// R3: group 2 enable pair decodes the same way
// R4: group 0 bits: timers, uart 0, i2c, spi, adc
// R5: group 1 bit follows port a or d choice
// R6: group 2 bits: timer 3, uart 1, dma, port c
// R7: group 2 low enable register at own address
// R8: forward requests only while globally enabled
// R9: highest level first; disabled never forwarded
package ipeb_pkg;

    // ------------------------------------------------------------------
    // register map
    // ------------------------------------------------------------------
    localparam int          ADDR_W          = 12;
    localparam int          DATA_W          = 8;
    localparam int          GROUPS          = 3;
    localparam int          SRC_N           = GROUPS * DATA_W;
    localparam int          IDX_W           = 5;
    localparam logic [11:0] OFS_G0_EN_HIGH  = 12'hFC1;
    localparam logic [11:0] OFS_G0_EN_LOW   = 12'hFC2;
    localparam logic [11:0] OFS_G1_EN_HIGH  = 12'hFC4;
    localparam logic [11:0] OFS_G1_EN_LOW   = 12'hFC5;
    localparam logic [11:0] OFS_G2_EN_HIGH  = 12'hFC7;
    localparam logic [11:0] OFS_G2_EN_LOW   = 12'hFC8;
    localparam logic [11:0] OFS_EVT_STATUS  = 12'hFC9;
    localparam logic [11:0] OFS_EVT_MASK    = 12'hFCA;
    localparam logic [11:0] OFS_ACTIVE      = 12'hFCB;

    localparam logic [7:0]  RST_ENABLE      = 8'h00;
    localparam logic [7:0]  RST_EVT_STATUS  = 8'h00;
    localparam logic [7:0]  RST_EVT_MASK    = 8'h00;

    // ------------------------------------------------------------------
    // event status / mask bit positions
    // ------------------------------------------------------------------
    localparam int          EVT_G0_NEW      = 0;
    localparam int          EVT_G1_NEW      = 1;
    localparam int          EVT_G2_NEW      = 2;
    localparam int          EVT_DROPPED     = 3;
    localparam int          EVT_N           = 4;

    // active register layout: [7] forwarding, [6:5] level, [4:0] index
    localparam int          ACT_FWD_BIT     = 7;
    localparam int          ACT_LVL_LSB     = 5;

    // group 0 source bits
    localparam int          G0_TIMER2       = 7;
    localparam int          G0_TIMER1       = 6;
    localparam int          G0_TIMER0       = 5;
    localparam int          G0_UART0_RX     = 4;
    localparam int          G0_UART0_TX     = 3;
    localparam int          G0_I2C          = 2;
    localparam int          G0_SPI          = 1;
    localparam int          G0_ADC          = 0;
    // group 2 source bits; bits 3..0 are port c pins 3..0
    localparam int          G2_TIMER3       = 7;
    localparam int          G2_UART1_RX     = 6;
    localparam int          G2_UART1_TX     = 5;
    localparam int          G2_DMA          = 4;

    typedef enum logic [1:0] {
        IPEB_LVL_OFF  = 2'b00,
        IPEB_LVL_LOW  = 2'b01,
        IPEB_LVL_NOM  = 2'b10,
        IPEB_LVL_HIGH = 2'b11
    } ipeb_level_t;

    // high enable bit is the msb of the level, low enable bit the lsb
    function automatic ipeb_level_t ipeb_decode(input logic en_high,
                                                input logic en_low);
        ipeb_level_t lvl;
        unique case ({en_high, en_low})
            2'b00: lvl = IPEB_LVL_OFF;
            2'b01: lvl = IPEB_LVL_LOW;
            2'b10: lvl = IPEB_LVL_NOM;
            2'b11: lvl = IPEB_LVL_HIGH;
        endcase
        return lvl;
    endfunction

endpackage
